//--- rtl/hpms_cfg.svh
// Offsets, field positions and reset values of the host port pin mode select block.
`ifndef HPMS_CFG_SVH
`define HPMS_CFG_SVH
`define HPMS_OFS_STATUS 4'h0
`define HPMS_OFS_MASK   4'h4
`define HPMS_OFS_MODE   4'h8
`define HPMS_OFS_CTRL   4'hC
`define HPMS_MASK_RST   3'h0
`define HPMS_CTRL_RST   8'h00
`define HPMS_EV_CORE    0
`define HPMS_EV_MODE    1
`define HPMS_EV_TSTR    2
`define HPMS_PIN_MISO   0
`define HPMS_PIN_MOSI   1
`define HPMS_PIN_SCLK   2
`define HPMS_MISO_OE    8'h01
`endif

//--- rtl/hpms_pkg.sv
// Types shared by the host port pin mode select block.
package hpms_pkg;
  typedef enum logic [1:0] {
    HPMS_MUX,
    HPMS_NONMUX,
    HPMS_SERIAL,
    HPMS_HW
  } hpms_mode_e;

  // Bits 7 down to 2 line up with shared bus pins 7 down to 2.
  typedef struct packed {
    logic       rx_term_disable;
    logic       tx_term_disable;
    logic [1:0] rx_framing_sel;
    logic       tx_sync_fn_sel;
    logic       rx_sync_fn_sel;
    logic [1:0] tx_mode_sel;
  } hpms_cfg_s;

  typedef struct packed {
    logic       jitter_in;
    logic       tristate_reset_pin;
    logic       tx_mode_sel2;
    logic       tx_mode_sel1;
    logic [1:0] host_if_sel;
    logic [7:0] bus;
  } hpms_pins_s;
endpackage : hpms_pkg

//--- rtl/hpms_top.sv
// Host port pin mode select with strap decode, pin steering, alert output and Avalon-MM registers.
// What this block does
// [R1] Pull open-drain alert low on flagged status outside hardware mode
// [R2] Far side drives jitter clock select high
// [R3] Hardware mode: tx mode from select pins
// [R4] Rising tristate/reset pin defaults mask and control, clears status but sets its tristate flag
// [R5] Tristate/reset high floats every driven pin
// [R6] Far side holds tristate/reset pin low
// [R7] Decode interface select into four modes
// [R8] Select 01: shared pins are data bus
// [R9] Select 00: shared pins carry address/data
// [R10] Hardware mode: rx termination disable pin
// [R11] Hardware mode: tx termination disable pin
// [R12] Hardware mode: rx framing from two pins
// [R13] Hardware mode: tx sync function pin
// [R14] Hardware mode: rx sync function pin
// [R15] Serial mode: bus bit 2 is clock
// [R16] Serial: read data bit 0, write bit 1
// [R17] Far side ties address pins low muxed
// [R18] Far side keeps straps static, resets after change
`include "hpms_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module hpms_top (
  // Clock, reset and freeze.
  input  wire logic                  clk,
  input  wire logic                  reset,
  input  wire logic                  ce,
  // Avalon-MM register slave.
  input  wire logic [3:0]            avs_address,
  input  wire logic                  avs_read,
  input  wire logic                  avs_write,
  input  wire logic [31:0]           avs_writedata,
  input  wire logic [3:0]            avs_byteenable,
  output logic      [31:0]           avs_readdata,
  output logic                       avs_waitrequest,
  output logic                       irq,
  // Device pins.
  input  wire logic [7:0]            bus_pin_in,
  output logic      [7:0]            bus_pin_out,
  output logic      [7:0]            bus_pin_oe,
  input  wire logic [1:0]            host_if_sel,
  input  wire logic                  tx_mode_sel1,
  input  wire logic                  tx_mode_sel2,
  input  wire logic                  tristate_reset_pin,
  input  wire logic                  alert_pin_in,
  output logic                       alert_pin_out,
  output logic                       alert_pin_oe,
  // Core side.
  input  wire logic                  core_event,
  input  wire logic [7:0]            par_rd_data,
  input  wire logic                  par_drive,
  input  wire logic                  ser_miso,
  input  wire logic                  ser_miso_en,
  output logic      [7:0]            par_pin_data,
  output logic                       ser_sclk,
  output logic                       ser_mosi,
  output hpms_pkg::hpms_mode_e       mode,
  output hpms_pkg::hpms_cfg_s        cfg,
  output logic                       jitter_clk_sel0,
  output logic                       ser_tristate
);

  function automatic hpms_pkg::hpms_mode_e decode_mode(input logic [1:0] sel);
    hpms_pkg::hpms_mode_e m;
    m = hpms_pkg::HPMS_MUX;
    unique case (sel)
      2'h0: m = hpms_pkg::HPMS_MUX;
      2'h1: m = hpms_pkg::HPMS_NONMUX;
      2'h2: m = hpms_pkg::HPMS_SERIAL;
      2'h3: m = hpms_pkg::HPMS_HW;
    endcase
    return m;
  endfunction : decode_mode

  hpms_pkg::hpms_pins_s pins_in;
  hpms_pkg::hpms_pins_s sync1_reg;
  hpms_pkg::hpms_pins_s sync2_reg;
  logic                 tstr_d_reg;
  logic                 tstr_rise;
  logic                 tstr_hold;
  hpms_pkg::hpms_mode_e mode_live;
  logic                 mode_chg;
  logic [2:0]           status_reg;
  logic [2:0]           status_next;
  logic [2:0]           mask_reg;
  hpms_pkg::hpms_cfg_s  ctrl_reg;
  hpms_pkg::hpms_cfg_s  cfg_next;
  logic [2:0]           rd_capture_reg;
  logic                 req;
  logic                 done;
  logic [31:0]          rd_value;

  assign pins_in = '{jitter_in: alert_pin_in, tristate_reset_pin: tristate_reset_pin,
                     tx_mode_sel2: tx_mode_sel2, tx_mode_sel1: tx_mode_sel1,
                     host_if_sel: host_if_sel, bus: bus_pin_in};

  // Every pin is asynchronous to clk, so only the second stage is read.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      tstr_d_reg <= 1'b0;
    end else if (ce) begin
      sync1_reg <= pins_in;
      sync2_reg <= sync1_reg;
      tstr_d_reg <= sync2_reg.tristate_reset_pin;
    end
  end

  assign tstr_rise = sync2_reg.tristate_reset_pin & ~tstr_d_reg; // [R4]
  assign tstr_hold = sync2_reg.tristate_reset_pin;
  assign mode_live = decode_mode(sync2_reg.host_if_sel); // [R7]
  assign mode_chg  = (mode_live != mode);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      mode <= hpms_pkg::HPMS_MUX;
    end else if (ce) begin
      mode <= mode_live; // [R7]
    end
  end

  // Hardware mode takes configuration from the straps, otherwise from software.
  always_comb begin
    cfg_next = ctrl_reg;
    if (mode_live == hpms_pkg::HPMS_HW) begin
      cfg_next.rx_term_disable = sync2_reg.bus[7]; // [R10]
      cfg_next.tx_term_disable = sync2_reg.bus[6]; // [R11]
      cfg_next.rx_framing_sel  = sync2_reg.bus[5:4]; // [R12]
      cfg_next.tx_sync_fn_sel  = sync2_reg.bus[3]; // [R13]
      cfg_next.rx_sync_fn_sel  = sync2_reg.bus[2]; // [R14]
      cfg_next.tx_mode_sel     = {sync2_reg.tx_mode_sel2, sync2_reg.tx_mode_sel1}; // [R3]
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cfg <= '0;
      jitter_clk_sel0 <= 1'b0;
    end else if (ce) begin
      cfg <= cfg_next;
      jitter_clk_sel0 <= (mode_live == hpms_pkg::HPMS_HW) & sync2_reg.jitter_in;
    end
  end

  // Pin steering; a released pin output is parked low only under tristate, in hardware mode and on serial bits 7 to 1.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      bus_pin_out <= 8'h00;
      bus_pin_oe <= 8'h00;
      par_pin_data <= 8'h00;
      ser_sclk <= 1'b0;
      ser_mosi <= 1'b0;
      ser_tristate <= 1'b0;
    end else if (ce) begin
      ser_tristate <= tstr_hold;
      par_pin_data <= sync2_reg.bus; // [R8] [R9]
      ser_sclk <= (mode_live == hpms_pkg::HPMS_SERIAL) & sync2_reg.bus[`HPMS_PIN_SCLK]; // [R15]
      ser_mosi <= (mode_live == hpms_pkg::HPMS_SERIAL) & sync2_reg.bus[`HPMS_PIN_MOSI]; // [R16]
      bus_pin_out <= 8'h00;
      bus_pin_oe <= 8'h00;
      if (tstr_hold) begin
        bus_pin_oe <= 8'h00; // [R5]
      end else begin
        unique case (mode_live)
          hpms_pkg::HPMS_MUX, hpms_pkg::HPMS_NONMUX: begin
            bus_pin_out <= par_rd_data; // [R8] [R9]
            bus_pin_oe <= {8{par_drive}};
          end
          hpms_pkg::HPMS_SERIAL: begin
            bus_pin_out[`HPMS_PIN_MISO] <= ser_miso; // [R16]
            bus_pin_oe <= ser_miso_en ? `HPMS_MISO_OE : 8'h00;
          end
          hpms_pkg::HPMS_HW: begin
            bus_pin_oe <= 8'h00;
          end
        endcase
      end
    end
  end

  // Alert is open-drain: the driven level is always low, only the enable moves.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      alert_pin_out <= 1'b0;
      alert_pin_oe <= 1'b0;
      irq <= 1'b0;
    end else if (ce) begin
      alert_pin_out <= 1'b0;
      irq <= |(status_next & mask_reg);
      alert_pin_oe <= |(status_next & mask_reg) & ~tstr_hold
                      & (mode_live != hpms_pkg::HPMS_HW); // [R1] [R5]
    end
  end

  // Avalon slave: one wait cycle, read data captured before the completing edge.
  assign req  = avs_read | avs_write;
  assign done = req & ~avs_waitrequest;

  always_comb begin
    rd_value = 32'h0000_0000;
    unique case (avs_address)
      `HPMS_OFS_STATUS: rd_value[2:0] = status_reg;
      `HPMS_OFS_MASK:   rd_value[2:0] = mask_reg;
      `HPMS_OFS_MODE:   rd_value[11:0] = {cfg, jitter_clk_sel0, tstr_hold, sync2_reg.host_if_sel};
      `HPMS_OFS_CTRL:   rd_value[7:0] = ctrl_reg;
      default:          rd_value = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
      rd_capture_reg <= 3'h0;
    end else if (ce) begin
      avs_waitrequest <= ~(req & avs_waitrequest);
      if (req & avs_waitrequest) begin
        avs_readdata <= avs_read ? rd_value : 32'h0000_0000;
        rd_capture_reg <= (avs_read && avs_address == `HPMS_OFS_STATUS) ? status_reg : 3'h0;
      end
    end
  end

  // Only the bits the reader saw are cleared; a new event still sets.
  always_comb begin
    status_next = status_reg;
    if (done & avs_read) begin
      status_next = status_reg & ~rd_capture_reg;
    end
    if (tstr_rise) begin
      status_next = 3'h0; // [R4]
    end
    status_next[`HPMS_EV_CORE] = status_next[`HPMS_EV_CORE] | core_event;
    status_next[`HPMS_EV_MODE] = status_next[`HPMS_EV_MODE] | mode_chg;
    status_next[`HPMS_EV_TSTR] = status_next[`HPMS_EV_TSTR] | tstr_rise;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      status_reg <= 3'h0;
    end else if (ce) begin
      status_reg <= status_next; // [R1]
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      mask_reg <= `HPMS_MASK_RST;
      ctrl_reg <= `HPMS_CTRL_RST;
    end else if (ce) begin
      if (tstr_rise) begin
        mask_reg <= `HPMS_MASK_RST; // [R4]
        ctrl_reg <= `HPMS_CTRL_RST; // [R4]
      end else if (done & avs_write & avs_byteenable[0]) begin
        if (avs_address == `HPMS_OFS_MASK) begin
          mask_reg <= avs_writedata[2:0];
        end
        if (avs_address == `HPMS_OFS_CTRL) begin
          ctrl_reg <= avs_writedata[7:0];
        end
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence tstr_edge_s;
    ce && tstr_rise;
  endsequence

  sequence regs_default_s;
    mask_reg == `HPMS_MASK_RST && ctrl_reg == `HPMS_CTRL_RST;
  endsequence

  chk_tstr_resets_regs: assert property ( // [R4]
    tstr_edge_s |=> regs_default_s)
    else $error("register set not defaulted after tristate rise");

  chk_tstr_floats_bus: assert property ( // [R5]
    ce && tstr_hold |=> bus_pin_oe == 8'h00 && !alert_pin_oe)
    else $error("pin driven while tristate held");

  chk_alert_follows_status: assert property ( // [R1]
    ce && |(status_next & mask_reg) && !tstr_hold && mode_live != hpms_pkg::HPMS_HW
    |=> alert_pin_oe && !alert_pin_out)
    else $error("alert not pulled low on flagged status");

  chk_alert_clear: assert property ( // [R1]
    ce && (status_next & mask_reg) == 3'h0 |=> !alert_pin_oe)
    else $error("alert driven with no flagged status");

  chk_mode_decode: assert property ( // [R7]
    ce |=> mode == decode_mode($past(sync2_reg.host_if_sel)))
    else $error("interface select decoded wrongly");

  chk_hw_straps: assert property ( // [R10] [R11] [R12] [R13] [R14]
    ce && mode_live == hpms_pkg::HPMS_HW |=> cfg[7:2] == $past(sync2_reg.bus[7:2]))
    else $error("hardware straps not applied");

  chk_hw_tx_mode: assert property ( // [R3]
    ce && mode_live == hpms_pkg::HPMS_HW
    |=> cfg.tx_mode_sel == {$past(sync2_reg.tx_mode_sel2), $past(sync2_reg.tx_mode_sel1)})
    else $error("transmit mode pins not applied");

  chk_serial_clk: assert property ( // [R15]
    ce && mode_live == hpms_pkg::HPMS_SERIAL |=> ser_sclk == $past(sync2_reg.bus[2]))
    else $error("serial clock not taken from bus bit 2");

  chk_serial_miso: assert property ( // [R16]
    ce && mode_live == hpms_pkg::HPMS_SERIAL && !tstr_hold && ser_miso_en
    |=> bus_pin_oe == `HPMS_MISO_OE && bus_pin_out[0] == $past(ser_miso))
    else $error("serial read data not on bus bit 0");

  chk_parallel_drive: assert property ( // [R8] [R9]
    ce && !tstr_hold && par_drive
    && (mode_live == hpms_pkg::HPMS_MUX || mode_live == hpms_pkg::HPMS_NONMUX)
    |=> bus_pin_oe == 8'hFF && bus_pin_out == $past(par_rd_data))
    else $error("parallel read data not driven");

endmodule : hpms_top

`default_nettype wire

//--- tb/hpms_host_model.sv
// Host and strap side of the shared pins: resolves the bus wires and the open-drain alert wire.
`timescale 1ns/1ps
`default_nettype none

module hpms_host_model (
  // Clock.
  input  wire logic       clk,
  // Device drive.
  input  wire logic [7:0] dev_out,
  input  wire logic [7:0] dev_oe,
  input  wire logic       alert_oe,
  // Host drive.
  input  wire logic [7:0] host_val,
  input  wire logic [7:0] host_oe,
  input  wire logic       jit_drive,
  input  wire logic       jit_val,
  // Resolved wires.
  output logic      [7:0] bus_wire,
  output logic            alert_wire
);
  logic [7:0] last_q;

  always_ff @(posedge clk) begin
    for (int i = 0; i < 8; i++) begin
      if (dev_oe[i] | host_oe[i]) begin
        last_q[i] <= bus_wire[i];
      end
    end
  end

  // A released wire has no pull, so it shows the inverse of its last level rather than a stale value.
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      bus_wire[i] = dev_oe[i] ? dev_out[i] : (host_oe[i] ? host_val[i] : ~last_q[i]);
    end
  end

  // The alert wire has a pull-up; in hardware mode the host drives it as a static strap.
  assign alert_wire = alert_oe ? 1'b0 : (jit_drive ? jit_val : 1'b1);
endmodule : hpms_host_model

`default_nettype wire

//--- tb/host_port_pin_mode_select_tb_top.sv
// Self-checking testbench of the host port pin mode select block.
`include "hpms_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module host_port_pin_mode_select_tb_top;
  logic clk = 0, reset = 1, ce = 1, rd_s = 0, wr_s = 0, core_event = 0, par_drive = 0;
  logic ser_miso = 0, ser_miso_en = 0, tx1 = 0, tx2 = 0, tri_pin = 0, jit_drive = 0, jit_val = 0;
  logic [3:0] addr = 4'h0, be = 4'hF;
  logic [31:0] wdata = 32'h0, rdata, q;
  logic [7:0] host_val = 8'h00, host_oe = 8'hFF, par_rd_data = 8'h00, bout, boe, bin, ppd;
  logic [1:0] sel = 2'h1;
  logic wreq, irq, a_out, a_oe, a_in, sclk, mosi, jit, sert;
  hpms_pkg::hpms_mode_e mode;
  hpms_pkg::hpms_cfg_s cfg;
  int mismatches = 0;
  int checks = 0;

  always #2 clk = ~clk;

  hpms_top u_dut (.clk(clk), .reset(reset), .ce(ce), .avs_address(addr), .avs_read(rd_s), .avs_write(wr_s),
    .avs_writedata(wdata), .avs_byteenable(be), .avs_readdata(rdata), .avs_waitrequest(wreq), .irq(irq),
    .bus_pin_in(bin), .bus_pin_out(bout), .bus_pin_oe(boe), .host_if_sel(sel), .tx_mode_sel1(tx1),
    .tx_mode_sel2(tx2), .tristate_reset_pin(tri_pin), .alert_pin_in(a_in), .alert_pin_out(a_out),
    .alert_pin_oe(a_oe), .core_event(core_event), .par_rd_data(par_rd_data), .par_drive(par_drive),
    .ser_miso(ser_miso), .ser_miso_en(ser_miso_en), .par_pin_data(ppd), .ser_sclk(sclk), .ser_mosi(mosi),
    .mode(mode), .cfg(cfg), .jitter_clk_sel0(jit), .ser_tristate(sert));

  hpms_host_model u_host (.clk(clk), .dev_out(bout), .dev_oe(boe), .alert_oe(a_oe), .host_val(host_val),
    .host_oe(host_oe), .jit_drive(jit_drive), .jit_val(jit_val), .bus_wire(bin), .alert_wire(a_in));

  task automatic final_report;
    if (mismatches == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : final_report

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      $display("BAD %s expected %h seen %h", nm, exp, got);
      mismatches++;
    end
  endtask : chk

  // One Avalon access; the request holds until waitrequest is sampled low.
  task automatic acc(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    addr <= a;
    wdata <= d;
    wr_s <= wr;
    rd_s <= !wr;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wreq !== 1'b0 && n < 50);
    r = rdata;
    if (wreq !== 1'b0) begin
      chk("waitrequest", 32'h0, 32'h1);
      final_report();
    end
    wr_s <= 1'b0;
    rd_s <= 1'b0;
    @(posedge clk);
  endtask : acc

  task automatic settle;
    repeat (4) @(posedge clk);
  endtask : settle

  task automatic t_decode;
    for (int i = 0; i < 4; i++) begin
      sel <= i[1:0];
      settle();
      chk("mode", i, {30'h0, mode});
    end
    // A low enable must hold the decoded mode although the select moves.
    ce <= 1'b0;
    sel <= 2'h0;
    settle();
    chk("freeze", 32'h3, {30'h0, mode});
    sel <= 2'h3;
    ce <= 1'b1;
    settle();
  endtask : t_decode

  task automatic t_hw(input logic [7:0] p, input logic t2, input logic t1);
    sel <= 2'h3;
    host_oe <= 8'hFF;
    host_val <= p;
    tx2 <= t2;
    tx1 <= t1;
    jit_drive <= 1'b1;
    jit_val <= 1'b1;
    par_drive <= 1'b1;
    settle();
    chk("cfg", {24'h0, p[7:2], t2, t1}, {24'h0, cfg});
    chk("bus_oe", 32'h0, {24'h0, boe});
    chk("jitter", 32'h1, {31'h0, jit});
    acc(1'b0, `HPMS_OFS_MODE, 32'h0, q);
    chk("mode_reg", {20'h0, p[7:2], t2, t1, 4'hB}, q);
  endtask : t_hw

  task automatic t_parallel;
    // Separate address inputs are not modelled; in mode 00 they count as tied low.
    for (int i = 0; i < 2; i++) begin
      sel <= i[1:0];
      par_drive <= 1'b1;
      par_rd_data <= 8'h3C ^ i[7:0];
      settle();
      chk("par_oe", 32'hFF, {24'h0, boe});
      chk("par_out", 32'h3C ^ i, {24'h0, bout});
    end
    par_drive <= 1'b0;
    host_val <= 8'hC3;
    // The device lets go of the lines one edge before the host level reaches the synchroniser.
    @(posedge clk);
    settle();
    chk("par_in", 32'hC3, {24'h0, ppd});
  endtask : t_parallel

  task automatic t_serial;
    sel <= 2'h2;
    host_oe <= 8'hFE;
    host_val <= 8'h06;
    ser_miso <= 1'b1;
    ser_miso_en <= 1'b1;
    settle();
    chk("sclk_mosi", 32'h3, {30'h0, sclk, mosi});
    chk("miso", 32'h1, {30'h0, boe[0], bout[0]} & 32'h3 ^ 32'h2);
    ser_miso_en <= 1'b0;
    host_oe <= 8'hFF;
    sel <= 2'h1;
    settle();
  endtask : t_serial

  task automatic t_irq;
    acc(1'b0, `HPMS_OFS_STATUS, 32'h0, q);
    acc(1'b1, `HPMS_OFS_MASK, 32'h7, q);
    core_event <= 1'b1;
    @(posedge clk);
    core_event <= 1'b0;
    repeat (2) @(posedge clk);
    chk("irq", 32'h6, {29'h0, irq, a_oe, a_out});
    acc(1'b0, `HPMS_OFS_STATUS, 32'h0, q);
    chk("status", 32'h1, q);
    repeat (2) @(posedge clk);
    chk("irq_clr", 32'h0, {30'h0, irq, a_oe});
    acc(1'b0, 4'h2, 32'h0, q);
    chk("unmapped", 32'h0, q);
  endtask : t_irq

  task automatic t_tristate;
    acc(1'b1, `HPMS_OFS_CTRL, 32'h5A, q);
    // The configuration output follows the control register one edge later.
    @(posedge clk);
    chk("cfg_ctrl", 32'h5A, {24'h0, cfg});
    par_drive <= 1'b1;
    tri_pin <= 1'b1;
    settle();
    chk("tri_oe", 32'h0, {23'h0, boe, a_oe});
    chk("tri_flag", 32'h1, {31'h0, sert});
    tri_pin <= 1'b0;
    settle();
    acc(1'b0, `HPMS_OFS_MASK, 32'h0, q);
    chk("mask_rst", 32'h0, q);
    acc(1'b0, `HPMS_OFS_CTRL, 32'h0, q);
    chk("ctrl_rst", 32'h0, q);
    acc(1'b0, `HPMS_OFS_STATUS, 32'h0, q);
    chk("status_tri", 32'h4, q);
  endtask : t_tristate

  initial begin
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    settle();
    t_decode();
    t_hw(8'hA4, 1'b1, 1'b0);
    t_hw(8'h58, 1'b0, 1'b1);
    jit_drive <= 1'b0;
    t_parallel();
    t_serial();
    t_irq();
    t_tristate();
    final_report();
  end
endmodule : host_port_pin_mode_select_tb_top

`default_nettype wire
